// ---- include/dmr_defs.svh ----
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH
// register indices; byte address is four times the index
`define DMR_IDX_MIC_EN 14'h0003
`define DMR_IDX_PWR 14'h0007
`define DMR_IDX_TX1L 14'h0606
`define DMR_IDX_TX1R 14'h0607
`define DMR_IDX_TX2L 14'h0608
`define DMR_IDX_TX2R 14'h0609
`define DMR_IDX_DACSEL 14'h060A
`define DMR_IDX_PULL 14'h0720
`define DMR_IDX_CLKCFG 14'h0740
`define DMR_IDX_STATUS 14'h0741
// writable bit masks; other bits read as zero
`define DMR_MASK_MIC_EN 16'h003C
`define DMR_MASK_PWR 16'h03FF
`define DMR_MASK_MIX 16'h0003
`define DMR_MASK_DACSEL 16'h0001
`define DMR_MASK_PULL 16'h1400
`define DMR_MASK_CLKCFG 16'h0001
// reset values
`define DMR_RST_ZERO 16'h0000
`define DMR_RST_PWR 16'h0010
`define DMR_RST_CLKCFG 16'h0001
// field positions
`define DMR_B_MIC2L 5
`define DMR_B_MIC2R 4
`define DMR_B_MIC1L 3
`define DMR_B_MIC1R 2
`define DMR_B_FN2 9
`define DMR_B_FN1 8
`define DMR_B_P2R_EN 7
`define DMR_B_P2L_EN 6
`define DMR_F_SRC2 5:4
`define DMR_B_P1R_EN 3
`define DMR_B_P1L_EN 2
`define DMR_F_SRC1 1:0
`define DMR_B_PD_B 12
`define DMR_B_PD_A 10
`define DMR_B_MIX_PATH 1
`define DMR_B_MIX_DAC 0
`define DMR_B_HIRATE 0
// source select encodings
`define DMR_SRC_ADC 2'h0
`define DMR_SRC_MIC_A 2'h1
`define DMR_SRC_MIC_B 2'h2
// mic clock half period in link clocks (divide by 4 or 8)
`define DMR_HALF_HI 3'h2
`define DMR_HALF_LO 3'h4
// pdm bit levels and filter shift
`define DMR_PDM_POS 16'h4000
`define DMR_PDM_NEG 16'hC000
`define DMR_LPF_SHIFT 4
`define DMR_CFG_W 24
`endif

// ---- include/dmr_pkg.sv ----
package dmr_pkg;
  // one audio sample, two's complement
  typedef logic signed [15:0] dmr_sample_t;
  // bus slave handshake states
  typedef enum logic {DMR_BUS_IDLE, DMR_BUS_ACK} dmr_bus_t;
endpackage

// ---- rtl/dmr_router.sv ----
// Function
// [R1] bit 2 enables mic pin a right channel
// [R2] bit 9 gives pin pair b to mics
// [R3] bit 8 gives pin pair a to mics
// [R4] per data pin pull-down, bits 12/10
// [R5] bits 1:0 select path 1 source
// [R6] bits 5:4 select path 2 source
// [R7] each path channel has its own enable
// [R8] low-pass filter in every input path
// [R9] four transmit mixers sum paths and DAC
// [R10] one common DAC source for all mixers
// [R11] 0606h bit 1 gates path 1L
// [R12] mixer outputs feed both transmit paths
// [R13] drive mic clock, high or low rate
// [R14] left on high phase, sample phase end
// [R15] mics release data line when idle
// [R16] disabled sources give zero; idle clock low
//
// Implementation choice: the Avalon-MM slave port.
`include "dmr_defs.svh"
module dmr_router (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic data_pin_a_pulldown_out,
  output logic data_pin_b_pulldown_out,
  output logic analog_in2_left_neg_avail_out,
  output logic analog_in2_right_neg_avail_out,
  input wire logic link_clk_in,
  input wire logic mic_data_pin_a_in,
  input wire logic mic_data_pin_b_in,
  output logic mic_clock_pin_a_out,
  output logic mic_clock_pin_b_out,
  input wire dmr_pkg::dmr_sample_t adc_left_in,
  input wire dmr_pkg::dmr_sample_t adc_right_in,
  input wire dmr_pkg::dmr_sample_t dac1_left_in,
  input wire dmr_pkg::dmr_sample_t dac1_right_in,
  input wire dmr_pkg::dmr_sample_t dac2_left_in,
  input wire dmr_pkg::dmr_sample_t dac2_right_in,
  output dmr_pkg::dmr_sample_t tx1_left_out,
  output dmr_pkg::dmr_sample_t tx1_right_out,
  output dmr_pkg::dmr_sample_t tx2_left_out,
  output dmr_pkg::dmr_sample_t tx2_right_out
);
  import dmr_pkg::*;

  // byte-lane merge of a write into a masked register
  function automatic logic [15:0] dmr_merge(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    dmr_merge = v & mask;
  endfunction

  // path source multiplexer; the reserved code gives silence
  function automatic dmr_sample_t dmr_src_mux(input logic [1:0] sel,
      input dmr_sample_t adc, input dmr_sample_t ma, input dmr_sample_t mb);
    unique case (sel)
      `DMR_SRC_ADC: dmr_src_mux = adc;
      `DMR_SRC_MIC_A: dmr_src_mux = ma;
      `DMR_SRC_MIC_B: dmr_src_mux = mb;
      default: dmr_src_mux = 16'sh0000;
    endcase
  endfunction

  // first-order low-pass step: y += (x - y) / 16
  function automatic dmr_sample_t dmr_lpf(input dmr_sample_t y,
      input dmr_sample_t x);
    logic signed [16:0] d;
    logic signed [16:0] s;
    d = 17'(x) - 17'(y);
    s = 17'(y) + (d >>> `DMR_LPF_SHIFT);
    dmr_lpf = s[15:0];
  endfunction

  // saturating two-input mix with per-input gates
  function automatic dmr_sample_t dmr_mix(input dmr_sample_t a,
      input logic ea, input dmr_sample_t b, input logic eb);
    logic signed [16:0] s;
    s = (ea ? 17'(a) : 17'sh00000) + (eb ? 17'(b) : 17'sh00000);
    if (s > 17'sh07FFF) begin
      dmr_mix = 16'sh7FFF;
    end else if (s < -17'sh08000) begin
      dmr_mix = 16'sh8000;
    end else begin
      dmr_mix = s[15:0];
    end
  endfunction

  // ---------------- register bus, system clock ----------------
  logic [15:0] mic_en_r; // mic channel enables
  logic [15:0] pwr_r; // pin function, path enables, sources
  logic [15:0] tx1l_r; // transmit 1 left gates
  logic [15:0] tx1r_r; // transmit 1 right gates
  logic [15:0] tx2l_r; // transmit 2 left gates
  logic [15:0] tx2r_r; // transmit 2 right gates
  logic [15:0] dacsel_r; // common DAC source
  logic [15:0] pull_r; // data pin pull-downs
  logic [15:0] clkcfg_r; // mic clock rate
  dmr_bus_t bus_r; // handshake state
  logic wait_r; // waitrequest flop
  logic [31:0] rdata_r; // read data flop
  logic pd_a_r; // pull-down a pin flop
  logic pd_b_r; // pull-down b pin flop
  logic avail_l_r; // analogue in2 left usable
  logic avail_r_r; // analogue in2 right usable
  logic [`DMR_CFG_W-1:0] cfg_r; // config snapshot sent to link side
  logic [1:0] act_s1_r; // link status, first stage
  logic [1:0] act_s2_r; // link status, second stage
  logic [1:0] act_r; // pairs driving a clock, written in the link domain

  // address decode
  wire [13:0] reg_idx = avs_address_in[15:2];
  wire bus_req = avs_read_in | avs_write_in;
  wire hit_mic = reg_idx == `DMR_IDX_MIC_EN;
  wire hit_pwr = reg_idx == `DMR_IDX_PWR;
  wire hit_t1l = reg_idx == `DMR_IDX_TX1L;
  wire hit_t1r = reg_idx == `DMR_IDX_TX1R;
  wire hit_t2l = reg_idx == `DMR_IDX_TX2L;
  wire hit_t2r = reg_idx == `DMR_IDX_TX2R;
  wire hit_dac = reg_idx == `DMR_IDX_DACSEL;
  wire hit_pull = reg_idx == `DMR_IDX_PULL;
  wire hit_clk = reg_idx == `DMR_IDX_CLKCFG;
  wire hit_stat = reg_idx == `DMR_IDX_STATUS;
  // a write lands only at the edge where waitrequest is seen low
  wire wr_fire = avs_write_in && (bus_r == DMR_BUS_ACK);
  wire [15:0] wd = avs_writedata_in[15:0];
  wire [1:0] be = avs_byteenable_in[1:0];
  wire bus_go = bus_req && (bus_r == DMR_BUS_IDLE);
  // unmapped addresses read zero; writes to them are dropped
  wire [15:0] rd_val = hit_mic ? mic_en_r :
                       hit_pwr ? pwr_r :
                       hit_t1l ? tx1l_r :
                       hit_t1r ? tx1r_r :
                       hit_t2l ? tx2l_r :
                       hit_t2r ? tx2r_r :
                       hit_dac ? dacsel_r :
                       hit_pull ? pull_r :
                       hit_clk ? clkcfg_r :
                       hit_stat ? {14'h0000, act_s2_r} : 16'h0000;
  // everything the link side needs, one word
  wire [`DMR_CFG_W-1:0] cfg_nxt = {
    clkcfg_r[`DMR_B_HIRATE],
    pwr_r[`DMR_B_FN2], pwr_r[`DMR_B_FN1], // [R2] [R3]
    mic_en_r[`DMR_B_MIC2L], mic_en_r[`DMR_B_MIC2R],
    mic_en_r[`DMR_B_MIC1L], mic_en_r[`DMR_B_MIC1R], // [R1]
    pwr_r[`DMR_F_SRC2], pwr_r[`DMR_F_SRC1],
    pwr_r[`DMR_B_P2R_EN], pwr_r[`DMR_B_P2L_EN],
    pwr_r[`DMR_B_P1R_EN], pwr_r[`DMR_B_P1L_EN],
    tx1l_r[1:0], tx1r_r[1:0], tx2l_r[1:0], tx2r_r[1:0],
    dacsel_r[0]};

  // handshake: one idle cycle with waitrequest high, then one low
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      bus_r <= DMR_BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_go ? DMR_BUS_ACK : DMR_BUS_IDLE;
      wait_r <= ~bus_go;
      if (bus_go && avs_read_in) begin
        rdata_r <= {16'h0000, rd_val};
      end
    end
  end

  // register writes
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mic_en_r <= `DMR_RST_ZERO; // [R1]
      pwr_r <= `DMR_RST_PWR; // [R2] [R3] [R5] [R6] [R7]
      tx1l_r <= `DMR_RST_ZERO; // [R11]
      tx1r_r <= `DMR_RST_ZERO;
      tx2l_r <= `DMR_RST_ZERO;
      tx2r_r <= `DMR_RST_ZERO;
      dacsel_r <= `DMR_RST_ZERO;
      pull_r <= `DMR_RST_ZERO; // [R4]
      clkcfg_r <= `DMR_RST_CLKCFG; // [R13]
    end else if (wr_fire) begin
      if (hit_mic) begin
        mic_en_r <= dmr_merge(mic_en_r, wd, be, `DMR_MASK_MIC_EN);
      end
      if (hit_pwr) begin
        pwr_r <= dmr_merge(pwr_r, wd, be, `DMR_MASK_PWR);
      end
      if (hit_t1l) begin
        tx1l_r <= dmr_merge(tx1l_r, wd, be, `DMR_MASK_MIX);
      end
      if (hit_t1r) begin
        tx1r_r <= dmr_merge(tx1r_r, wd, be, `DMR_MASK_MIX);
      end
      if (hit_t2l) begin
        tx2l_r <= dmr_merge(tx2l_r, wd, be, `DMR_MASK_MIX);
      end
      if (hit_t2r) begin
        tx2r_r <= dmr_merge(tx2r_r, wd, be, `DMR_MASK_MIX);
      end
      if (hit_dac) begin
        dacsel_r <= dmr_merge(dacsel_r, wd, be, `DMR_MASK_DACSEL);
      end
      if (hit_pull) begin
        pull_r <= dmr_merge(pull_r, wd, be, `DMR_MASK_PULL);
      end
      if (hit_clk) begin
        clkcfg_r <= dmr_merge(clkcfg_r, wd, be, `DMR_MASK_CLKCFG);
      end
    end
  end

  // pin-side controls and the config snapshot, all from flops
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pd_a_r <= 1'b0;
      pd_b_r <= 1'b0;
      avail_l_r <= 1'b1;
      avail_r_r <= 1'b1;
      cfg_r <= '0;
      act_s1_r <= 2'h0;
      act_s2_r <= 2'h0;
    end else begin
      pd_a_r <= pull_r[`DMR_B_PD_A]; // [R4]
      pd_b_r <= pull_r[`DMR_B_PD_B]; // [R4]
      avail_l_r <= ~pwr_r[`DMR_B_FN1]; // [R3]
      avail_r_r <= ~pwr_r[`DMR_B_FN2]; // [R2]
      cfg_r <= cfg_nxt;
      act_s1_r <= act_r;
      act_s2_r <= act_s1_r;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign data_pin_a_pulldown_out = pd_a_r;
  assign data_pin_b_pulldown_out = pd_b_r;
  assign analog_in2_left_neg_avail_out = avail_l_r;
  assign analog_in2_right_neg_avail_out = avail_r_r;

  // ---------------- link side, link clock ----------------
  // config is quasi-static, so a plain two-stage crossing per bit is
  // enough; a field changing mid-transfer may mix old and new for a cycle
  logic lrst_s1_r; // reset crossing, first stage
  logic lrst_n_r; // link reset, active low
  logic [`DMR_CFG_W-1:0] cfg_s1_r; // config crossing, first stage
  logic [`DMR_CFG_W-1:0] cfg_s2_r; // config as seen by link logic
  logic [1:0] dat_s1_r; // data pins, first stage
  logic [1:0] dat_s2_r; // data pins, usable
  logic [2:0] div_r; // half-period counter
  logic ph_r; // mic clock phase, 1 = high
  logic clk_a_r; // clock pin a flop
  logic clk_b_r; // clock pin b flop
  dmr_sample_t mic_r [4]; // 0 a left, 1 a right, 2 b left, 3 b right
  dmr_sample_t lpf_r [4]; // 0 1L, 1 1R, 2 2L, 3 2R
  dmr_sample_t tx_r [4]; // 0 tx1 left, 1 tx1 right, 2 tx2 left, 3 tx2 right

  // config unpacking
  wire l_hirate = cfg_s2_r[23];
  wire l_fn_b = cfg_s2_r[22];
  wire l_fn_a = cfg_s2_r[21];
  wire [3:0] l_mic_en = {cfg_s2_r[19], cfg_s2_r[20], cfg_s2_r[17], cfg_s2_r[18]};
  wire [1:0] l_src2 = cfg_s2_r[16:15];
  wire [1:0] l_src1 = cfg_s2_r[14:13];
  wire [3:0] l_path_en = {cfg_s2_r[12], cfg_s2_r[11], cfg_s2_r[10], cfg_s2_r[9]};
  wire [7:0] l_mix = cfg_s2_r[8:1]; // per mixer {path, dac}
  wire l_dacsel = cfg_s2_r[0];

  // mic clock divider
  wire [2:0] half = l_hirate ? `DMR_HALF_HI : `DMR_HALF_LO; // [R13]
  wire toggle = div_r == (half - 3'h1);
  wire ph_nxt = toggle ? ~ph_r : ph_r;
  // a pair counts only while its pins belong to the mic function
  wire [3:0] ch_live = l_mic_en & {l_fn_b, l_fn_b, l_fn_a, l_fn_a};
  wire [1:0] cap_bit = dat_s2_r;

  // input paths: select, gate, filter
  dmr_sample_t raw [4];
  assign raw[0] = dmr_src_mux(l_src1, adc_left_in, mic_r[0], mic_r[2]); // [R5]
  assign raw[1] = dmr_src_mux(l_src1, adc_right_in, mic_r[1], mic_r[3]); // [R5]
  assign raw[2] = dmr_src_mux(l_src2, adc_left_in, mic_r[0], mic_r[2]); // [R6]
  assign raw[3] = dmr_src_mux(l_src2, adc_right_in, mic_r[1], mic_r[3]); // [R6]
  // disabled channels feed zero downstream
  dmr_sample_t path [4];
  assign path[0] = l_path_en[0] ? lpf_r[0] : 16'sh0000; // [R7] [R16]
  assign path[1] = l_path_en[1] ? lpf_r[1] : 16'sh0000; // [R7] [R16]
  assign path[2] = l_path_en[2] ? lpf_r[2] : 16'sh0000; // [R7] [R16]
  assign path[3] = l_path_en[3] ? lpf_r[3] : 16'sh0000; // [R7] [R16]
  // one DAC pair feeds every mixer
  wire dmr_sample_t dac_l = l_dacsel ? dac2_left_in : dac1_left_in; // [R10]
  wire dmr_sample_t dac_r = l_dacsel ? dac2_right_in : dac1_right_in; // [R10]

  // reset and config crossings
  always_ff @(posedge link_clk_in) begin
    lrst_s1_r <= reset_n_in;
    lrst_n_r <= lrst_s1_r;
    cfg_s1_r <= cfg_r;
    cfg_s2_r <= cfg_s1_r;
    dat_s1_r <= {mic_data_pin_b_in, mic_data_pin_a_in};
    dat_s2_r <= dat_s1_r;
  end

  // mic clock generation; an unassigned pair holds its pin low
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_r) begin
      div_r <= 3'h0;
      ph_r <= 1'b0;
      clk_a_r <= 1'b0;
      clk_b_r <= 1'b0;
      act_r <= 2'h0;
    end else begin
      div_r <= toggle ? 3'h0 : div_r + 3'h1;
      ph_r <= ph_nxt;
      clk_a_r <= ph_nxt & l_fn_a; // [R3] [R13] [R16]
      clk_b_r <= ph_nxt & l_fn_b; // [R2] [R13] [R16]
      act_r <= {l_fn_b, l_fn_a};
    end
  end

  // capture one cycle past each phase end, so the two-flop pin delay
  // lands on the last link edge inside the phase at either rate; high phase is left, low phase right
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_r) begin
      for (int i = 0; i < 4; i++) begin
        mic_r[i] <= 16'sh0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!ch_live[i]) begin
          mic_r[i] <= 16'sh0000; // [R1] [R16]
        end else if ((div_r == 3'h0) && (ph_r == ((i % 2) == 1))) begin // [R14] [R15]
          mic_r[i] <= cap_bit[i / 2] ? `DMR_PDM_POS : `DMR_PDM_NEG;
        end
      end
    end
  end

  // per-path low-pass filter; a disabled path restarts from zero
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_r) begin
      for (int i = 0; i < 4; i++) begin
        lpf_r[i] <= 16'sh0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        lpf_r[i] <= l_path_en[i] ? dmr_lpf(lpf_r[i], raw[i]) : 16'sh0000; // [R8]
      end
    end
  end

  // transmit mixers: path gate in bit 1, DAC gate in bit 0
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_r) begin
      for (int i = 0; i < 4; i++) begin
        tx_r[i] <= 16'sh0000;
      end
    end else begin
      tx_r[0] <= dmr_mix(path[0], l_mix[7], dac_l, l_mix[6]); // [R9] [R11]
      tx_r[1] <= dmr_mix(path[1], l_mix[5], dac_r, l_mix[4]); // [R9]
      tx_r[2] <= dmr_mix(path[2], l_mix[3], dac_l, l_mix[2]); // [R9]
      tx_r[3] <= dmr_mix(path[3], l_mix[1], dac_r, l_mix[0]); // [R9]
    end
  end

  // transmit path outputs toward both audio interfaces
  assign tx1_left_out = tx_r[0]; // [R12]
  assign tx1_right_out = tx_r[1]; // [R12]
  assign tx2_left_out = tx_r[2]; // [R12]
  assign tx2_right_out = tx_r[3]; // [R12]
  assign mic_clock_pin_a_out = clk_a_r;
  assign mic_clock_pin_b_out = clk_b_r;
endmodule // dmr_router

// ---- verif/dmr_router_props.sv ----
`include "dmr_defs.svh"
module dmr_router_props (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic data_pin_a_pulldown_out,
  input wire logic data_pin_b_pulldown_out,
  input wire logic analog_in2_left_neg_avail_out,
  input wire logic analog_in2_right_neg_avail_out,
  input wire logic link_clk_in,
  input wire logic mic_clock_pin_a_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // writes the slave accepts at this edge, upper byte lane on
  wire logic wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[1];
  wire logic wr_pull = wr_ok && (avs_address_in[15:2] == `DMR_IDX_PULL);
  wire logic wr_pwr = wr_ok && (avs_address_in[15:2] == `DMR_IDX_PWR);
  logic [3:0] idle_r; // link cycles with pair a unassigned, saturating
  logic [3:0] run_r; // link cycles with pair a assigned, saturating
  logic [3:0] half_r; // link cycles since the clock pin last moved
  logic clk_q_r; // clock pin one link cycle ago
  // counters sample a sys-domain level; a few cycles of skew are absorbed by the thresholds
  always_ff @(posedge link_clk_in) begin
    if (!reset_n_in) begin
      idle_r <= 4'h0;
      run_r <= 4'h0;
      half_r <= 4'hF;
      clk_q_r <= 1'b0;
    end else begin
      idle_r <= analog_in2_left_neg_avail_out ? idle_r + {3'h0, idle_r != 4'hF} : 4'h0;
      run_r <= analog_in2_left_neg_avail_out ? 4'h0 : run_r + {3'h0, run_r != 4'hF};
      half_r <= (mic_clock_pin_a_out != clk_q_r) ? 4'h1 : half_r + {3'h0, half_r != 4'hF};
      clk_q_r <= mic_clock_pin_a_out;
    end
  end
  AST_WAIT_ANSWER: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered one cycle after it was taken");
  AST_WAIT_ONE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_CAUSE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
    else $error("answer without a request");
  AST_PD_SET: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_pull |-> ##2 {data_pin_b_pulldown_out, data_pin_a_pulldown_out} ==
      {$past(avs_writedata_in[12], 2), $past(avs_writedata_in[10], 2)})
    else $error("pull-down enables differ from the written bits");
  AST_PD_HOLD: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !wr_pull && !$past(wr_pull) |=> $stable({data_pin_b_pulldown_out, data_pin_a_pulldown_out}))
    else $error("pull-down changed without a write");
  AST_AVAIL_A: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_pwr |-> ##2 analog_in2_left_neg_avail_out == !$past(avs_writedata_in[8], 2))
    else $error("pair a function and analogue availability disagree");
  AST_AVAIL_B: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr_pwr |-> ##2 analog_in2_right_neg_avail_out == !$past(avs_writedata_in[9], 2))
    else $error("pair b function and analogue availability disagree");
  AST_CLK_IDLE: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    idle_r >= 4'h8 |-> !mic_clock_pin_a_out)
    else $error("clock pin a runs while pair a is unassigned");
  AST_CLK_HALF: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    (mic_clock_pin_a_out != clk_q_r) && run_r == 4'hF && half_r < 4'h9 |->
      half_r == 4'h2 || half_r == 4'h4)
    else $error("clock pin a half period is neither 2 nor 4 link cycles");
endmodule // dmr_router_props
bind dmr_router dmr_router_props dmr_router_props_i (.sys_clk_in, .reset_n_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
  .data_pin_a_pulldown_out, .data_pin_b_pulldown_out, .analog_in2_left_neg_avail_out,
  .analog_in2_right_neg_avail_out, .link_clk_in, .mic_clock_pin_a_out);

// ---- verif/dmr_mic_pair_model.sv ----
module dmr_mic_pair_model (
  input wire logic clk_pin_in,
  input wire logic pulldown_in,
  input wire logic left_bit_in,
  input wire logic right_bit_in,
  output logic data_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_en = 1'b1; // one of the two mics holds the line
  logic last_bit = 1'b0; // level the line carried before release
  // turnaround after each clock edge: both mics off the line for 2 ns
  always @(clk_pin_in) begin
    last_bit = clk_pin_in ? right_bit_in : left_bit_in;
    drive_en = 1'b0;
    #2 drive_en = 1'b1;
  end
  // left mic in the high phase, right mic in the low phase
  // a released line falls to the pull-down, else shows the inverse of its last level
  assign data_pin_out = drive_en ? (clk_pin_in ? left_bit_in : right_bit_in)
                                 : (pulldown_in ? 1'b0 : ~last_bit);
endmodule // dmr_mic_pair_model

// ---- verif/testbench.sv ----
`include "dmr_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dmr_pkg::*;
  logic sys_clk, link_clk, reset_n, rd, wr; // clocks, reset, bus strobes
  logic [15:0] addr; // bus byte address
  logic [31:0] wdata, rdata; // bus data
  logic wait_w, pd_a, pd_b, av_a, av_b, clk_a, clk_b; // device status pins
  logic a_left, a_right, b_left, b_right; // bit each mic sends
  wire logic pin_a, pin_b; // shared data lines
  dmr_sample_t adc_l, adc_r, dac1_l, dac1_r, dac2_l, dac2_r; // sample inputs
  dmr_sample_t tx_w [4]; // mixers 1L 1R 2L 2R
  int n_fail = 0;
  int num_checks = 0;
  // reset table; the last index is unmapped
  logic [13:0] ridx [6] = '{`DMR_IDX_MIC_EN, `DMR_IDX_PWR, `DMR_IDX_TX1L, `DMR_IDX_PULL,
    `DMR_IDX_CLKCFG, 14'h0100};
  logic [31:0] rval [6] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h1, 32'h0};
  dmr_router dmr_router_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_w), .data_pin_a_pulldown_out(pd_a),
    .data_pin_b_pulldown_out(pd_b), .analog_in2_left_neg_avail_out(av_a),
    .analog_in2_right_neg_avail_out(av_b), .link_clk_in(link_clk), .mic_data_pin_a_in(pin_a),
    .mic_data_pin_b_in(pin_b), .mic_clock_pin_a_out(clk_a), .mic_clock_pin_b_out(clk_b),
    .adc_left_in(adc_l), .adc_right_in(adc_r), .dac1_left_in(dac1_l), .dac1_right_in(dac1_r),
    .dac2_left_in(dac2_l), .dac2_right_in(dac2_r), .tx1_left_out(tx_w[0]),
    .tx1_right_out(tx_w[1]), .tx2_left_out(tx_w[2]), .tx2_right_out(tx_w[3]));
  dmr_mic_pair_model mic_pair_a (.clk_pin_in(clk_a), .pulldown_in(pd_a), .left_bit_in(a_left),
    .right_bit_in(a_right), .data_pin_out(pin_a));
  dmr_mic_pair_model mic_pair_b (.clk_pin_in(clk_b), .pulldown_in(pd_b), .left_bit_in(b_left),
    .right_bit_in(b_right), .data_pin_out(pin_b));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // 6 ns link clock, offset so its edges never meet the system clock's
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // filter outputs settle near, not on, the target
  task automatic near(input string what, input dmr_sample_t exp, input dmr_sample_t got);
    int d;
    d = int'(exp) - int'(got);
    num_checks++;
    if ((^got === 1'bx) || d > 64 || d < -64) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [13:0] idx, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    rd <= !is_wr;
    wr <= is_wr;
    addr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    do @(posedge sys_clk); while (wait_w !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_reg(input logic [13:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    chk("readdata", exp, q);
  endtask
  task automatic lwait(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // length of one high phase of clock pin a, in link cycles
  task automatic half(input int exp);
    int n;
    n = 0;
    lwait(20);
    while (clk_a === 1'b1 && n < 50) begin @(posedge link_clk); n++; end
    while (clk_a !== 1'b1 && n < 100) begin @(posedge link_clk); n++; end
    n = 0;
    while (clk_a === 1'b1 && n < 50) begin @(posedge link_clk); n++; end
    chk("mic clock half period", 32'(exp), 32'(n));
  endtask
  initial begin
    #60000;
    chk("watchdog", 32'h1, 32'h0);
    report_and_stop();
  end
  initial begin
    {reset_n, rd, wr, addr, wdata} = '0;
    {adc_l, adc_r, dac1_l, dac1_r, dac2_l, dac2_r} = '0;
    {a_left, a_right, b_left, b_right} = 4'h9;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    lwait(2);
    chk("pin status", 32'h3, {28'h0, pd_b, pd_a, av_b, av_a});
    chk("idle clocks", 32'h0, {30'h0, clk_b, clk_a});
    for (int i = 0; i < 6; i++) rd_chk(ridx[i], rval[i]);
    // pull-downs: only the two documented bits stick
    wr_reg(`DMR_IDX_PULL, 16'hFFFF);
    rd_chk(`DMR_IDX_PULL, 32'h1400);
    chk("pulldowns", 32'h3, {30'h0, pd_b, pd_a});
    wr_reg(`DMR_IDX_PULL, 16'h0400);
    repeat (2) @(posedge sys_clk);
    chk("pulldowns", 32'h1, {30'h0, pd_b, pd_a});
    // pair a at the low rate into path 1, left and right
    wr_reg(`DMR_IDX_CLKCFG, 16'h0000);
    wr_reg(`DMR_IDX_MIC_EN, 16'h000C);
    wr_reg(`DMR_IDX_TX1L, 16'h0002);
    wr_reg(`DMR_IDX_TX1R, 16'h0002);
    wr_reg(`DMR_IDX_PWR, 16'h010D);
    repeat (2) @(posedge sys_clk);
    chk("analogue avail", 32'h2, {30'h0, av_b, av_a});
    half(4);
    lwait(300);
    near("tx1 left", 16'sh4000, tx_w[0]);
    near("tx1 right", 16'shC000, tx_w[1]);
    wr_reg(`DMR_IDX_MIC_EN, 16'h0008);
    lwait(300);
    near("tx1 right off", 16'sh0000, tx_w[1]);
    wr_reg(`DMR_IDX_TX1L, 16'h0000);
    lwait(20);
    near("tx1 left gated", 16'sh0000, tx_w[0]);
    wr_reg(`DMR_IDX_TX1L, 16'h0002);
    wr_reg(`DMR_IDX_PWR, 16'h010F);
    lwait(300);
    near("reserved source", 16'sh0000, tx_w[0]);
    // path 1 from pin b, whose left mic sends zeros
    wr_reg(`DMR_IDX_MIC_EN, 16'h0028);
    wr_reg(`DMR_IDX_PWR, 16'h0306);
    lwait(300);
    near("tx1 left from b", 16'shC000, tx_w[0]);
    rd_chk(`DMR_IDX_STATUS, 32'h3);
    chk("analogue avail", 32'h0, {30'h0, av_b, av_a});
    // clocks stop, then pair a again at the high rate
    wr_reg(`DMR_IDX_PWR, 16'h0000);
    lwait(20);
    chk("idle clocks", 32'h0, {30'h0, clk_b, clk_a});
    wr_reg(`DMR_IDX_CLKCFG, 16'h0001);
    wr_reg(`DMR_IDX_PWR, 16'h0100);
    half(2);
    // all four mixers on the DAC input, both settings of the common selector
    wr_reg(`DMR_IDX_PWR, 16'h0040);
    @(posedge link_clk);
    {dac1_l, dac1_r, dac2_l, dac2_r} <= {16'sh1111, 16'sh2222, 16'sh3333, 16'sh4444};
    for (int m = 0; m < 4; m++) wr_reg(14'(`DMR_IDX_TX1L + m), 16'h0001);
    for (int s = 0; s < 2; s++) begin
      wr_reg(`DMR_IDX_DACSEL, 16'(s));
      lwait(20);
      for (int m = 0; m < 4; m++) near("tx dac", 16'(32'h1111 * (1 + m % 2 + 2 * s)), tx_w[m]);
    end
    // step on the ADC into path 2 left: the filter smooths it
    wr_reg(`DMR_IDX_TX2L, 16'h0002);
    lwait(300);
    @(posedge link_clk);
    adc_l <= 16'sh2000;
    lwait(4);
    chk("filter step", 32'h1, {31'h0, tx_w[2] < 16'sh1000});
    lwait(300);
    near("tx2 left", 16'sh2000, tx_w[2]);
    report_and_stop();
  end
endmodule // testbench
